// File: spimsp_regs.vh
// Purpose: register map and field layout of the serial port
// Assumes: APB byte addresses, one register per aligned word
// Notes: all values shared by the port and its bench
`ifndef SPIMSP_REGS_VH
`define SPIMSP_REGS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPIMSP_CTRL_OFF 12'h000
`define SPIMSP_STAT_OFF 12'h004
`define SPIMSP_DATA_OFF 12'h008
`define SPIMSP_PIN_OFF 12'h00C
// ----------------------------------------
// control fields
// ----------------------------------------
`define SPIMSP_CTRL_IE 7
`define SPIMSP_CTRL_EN 6
`define SPIMSP_CTRL_LSB 5
`define SPIMSP_CTRL_MASTER_ROLE_SELECT 4
`define SPIMSP_CTRL_CPOL 3
`define SPIMSP_CTRL_CPHA 2
// ----------------------------------------
// status fields
// ----------------------------------------
`define SPIMSP_STAT_DONE 7
`define SPIMSP_STAT_WRITE_COLLISION_FLAG 6
`define SPIMSP_STAT_DBL 0
// ----------------------------------------
// pin config fields (direction and ss level)
// ----------------------------------------
`define SPIMSP_PIN_SS_OUT 0
`define SPIMSP_PIN_SS_LVL 1
`define SPIMSP_PIN_MOSI_OE 2
`define SPIMSP_PIN_MISO_OE 3
`define SPIMSP_PIN_SCK_OE 4
// ----------------------------------------
// reset values and bits per byte
// ----------------------------------------
`define SPIMSP_CTRL_RST 8'h00
`define SPIMSP_PIN_RST 5'h02
`define SPIMSP_BYTE_BITS 4'h8
`endif

// File: spimsp_port.v
// Purpose: byte SPI port, master or slave, with APB register access
// Assumes: one 250 MHz clock; pins sampled through two flip-flops
// Notes: half-period count in system clocks is divider / 2
//
// Behaviour
// - slave with select low is active; miso driven only if enabled
// - slave with select high keeps pins as inputs and ignores data
// - select rising in slave clears bit counter and partial shift data
// - master with select as output: plain output, no effect on port
// - select input low in master clears master bit, becomes slave
// - forced demotion sets done flag and raises interrupt if enabled
// - interrupt only when done flag, enable bit and global enable set
// - port enable bit gates every transfer in both roles
// - bit order one sends lsb first, zero sends msb first
// - role bit one selects master, zero selects slave
// - polarity one idles sck high, zero idles sck low
// - phase zero samples leading edge, one samples trailing edge
// - rate bits act only in master role
// - normal speed divides clock by 4, 16, 64, 128
// - double speed divides clock by 2, 8, 32, 64
// - master data write runs eight bits then sets done flag
// - transmit single buffered, receive double buffered
// - done clears on vector ack or status read then data access
// - data write during a transfer sets collision flag
`include "spimsp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module spimsp_port (
  input wire CLK_SYS_IN,
  input wire RST_N_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [11:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output wire [31:0] PRDATA_OUT,
  output wire PREADY_OUT,
  output wire PSLVERR_OUT,
  input wire GLOBAL_IRQ_EN_IN,
  input wire IRQ_ACK_IN,
  output wire IRQ_OUT,
  input wire SCK_IN,
  output wire SCK_OUT,
  output wire SCK_OE_OUT,
  input wire MOSI_IN,
  output wire MOSI_OUT,
  output wire MOSI_OE_OUT,
  input wire MISO_IN,
  output wire MISO_OUT,
  output wire MISO_OE_OUT,
  input wire SS_N_IN,
  output wire SS_N_OUT,
  output wire SS_N_OE_OUT
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] ctrl_ff;
  reg dbl_ff;
  reg [4:0] pin_ff;
  reg done_ff;
  reg write_collision_flag_ff;
  reg armed_ff;
  reg [7:0] shift_ff;
  reg [7:0] rxbuf_ff;
  reg [2:0] cnt_ff;
  reg busy_ff;
  reg sck_ff;
  reg [6:0] div_ff;
  reg half_ff;
  reg mosi_ff;
  reg [2:0] sck_s_ff;
  reg [1:0] ss_s_ff;
  reg [1:0] mosi_s_ff;
  reg [1:0] miso_s_ff;
  reg ss_d_ff;
  reg [31:0] rdata_ff;
  reg [1:0] msamp_d_ff;
  reg [1:0] mlast_d_ff;
  reg [7:0] mrx_ff;
  wire en = ctrl_ff[`SPIMSP_CTRL_EN];
  wire lsb = ctrl_ff[`SPIMSP_CTRL_LSB];
  wire master_role_select = ctrl_ff[`SPIMSP_CTRL_MASTER_ROLE_SELECT];
  wire cpol = ctrl_ff[`SPIMSP_CTRL_CPOL];
  wire cpha = ctrl_ff[`SPIMSP_CTRL_CPHA];
  wire ss_in_mode = ~pin_ff[`SPIMSP_PIN_SS_OUT];
  wire ss_n = ss_s_ff[1];
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire acc = PSEL_IN & PENABLE_IN;
  wire wr = acc & PWRITE_IN;
  wire rd = acc & ~PWRITE_IN;
  wire a_ctrl = (PADDR_IN == `SPIMSP_CTRL_OFF);
  wire a_stat = (PADDR_IN == `SPIMSP_STAT_OFF);
  wire a_data = (PADDR_IN == `SPIMSP_DATA_OFF);
  wire a_pin = (PADDR_IN == `SPIMSP_PIN_OFF);
  wire mapped = a_ctrl | a_stat | a_data | a_pin;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = acc & ~mapped;
  assign PRDATA_OUT = rdata_ff;
  wire data_acc = acc & a_data;
  wire data_wr = wr & a_data;
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      sck_s_ff <= 3'h0;
      ss_s_ff <= 2'h3;
      ss_d_ff <= 1'b1;
      mosi_s_ff <= 2'h0;
      miso_s_ff <= 2'h0;
    end else begin
      sck_s_ff <= {sck_s_ff[1:0], SCK_IN};
      ss_s_ff <= {ss_s_ff[0], SS_N_IN};
      ss_d_ff <= ss_s_ff[1];
      mosi_s_ff <= {mosi_s_ff[0], MOSI_IN};
      miso_s_ff <= {miso_s_ff[0], MISO_IN};
    end
  end
  // ----------------------------------------
  // edge classification
  // ----------------------------------------
  // divider half period: full ratio / 2, minus one
  reg [6:0] half_max;
  always @* begin
    case ({dbl_ff, ctrl_ff[1:0]})
      3'h0: half_max = 7'h01;
      3'h1: half_max = 7'h07;
      3'h2: half_max = 7'h1F;
      3'h3: half_max = 7'h3F;
      3'h4: half_max = 7'h00;
      3'h5: half_max = 7'h03;
      3'h6: half_max = 7'h0F;
      default: half_max = 7'h1F;
    endcase
  end
  wire tick = busy_ff & master_role_select & (div_ff == half_max);
  // slave edges from synchronised sck; first stage not read here
  wire s_rise = sck_s_ff[1] & ~sck_s_ff[2];
  wire s_fall = ~sck_s_ff[1] & sck_s_ff[2];
  wire s_active = en & ~master_role_select & ~ss_n;
  wire s_lead = s_active & (cpol ? s_fall : s_rise);
  wire s_trail = s_active & (cpol ? s_rise : s_fall);
  // master: half_ff low means next toggle is a leading edge
  wire m_lead = tick & ~half_ff;
  wire m_trail = tick & half_ff;
  wire lead = master_role_select ? m_lead : s_lead;
  wire trail = master_role_select ? m_trail : s_trail;
  wire samp = cpha ? trail : lead;
  wire setup = cpha ? lead : trail;
  wire din = master_role_select ? miso_s_ff[1] : mosi_s_ff[1];
  wire last = samp & (cnt_ff == 3'h7);
  // master ends on the trailing edge that closes the eighth bit
  wire m_end = m_trail & (cpha ? (cnt_ff == 3'h7) : (cnt_ff == 3'h0));
  // master miso is taken two clocks late to cover its synchroniser
  wire [7:0] nxt_mrx = lsb ? {miso_s_ff[1], mrx_ff[7:1]} : {mrx_ff[6:0], miso_s_ff[1]};
  wire out_bit = lsb ? shift_ff[0] : shift_ff[7];
  wire demote = en & master_role_select & ss_in_mode & ~ss_n;
  wire ss_rise = ~master_role_select & ss_n & ~ss_d_ff;
  // ----------------------------------------
  // control, status and pin config registers
  // ----------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      ctrl_ff <= `SPIMSP_CTRL_RST;
      dbl_ff <= 1'b0;
      pin_ff <= `SPIMSP_PIN_RST;
    end else begin
      if (wr & a_ctrl)
        ctrl_ff <= PWDATA_IN[7:0];
      if (demote)
        ctrl_ff[`SPIMSP_CTRL_MASTER_ROLE_SELECT] <= 1'b0;
      if (wr & a_stat)
        dbl_ff <= PWDATA_IN[`SPIMSP_STAT_DBL];
      if (wr & a_pin)
        pin_ff <= PWDATA_IN[4:0];
    end
  end
  // ----------------------------------------
  // flags: done and collision, set beats clear
  // ----------------------------------------
  wire done_set = (last & ~master_role_select) | mlast_d_ff[1] | demote;
  wire write_collision_flag_set = data_wr & busy_ff;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      done_ff <= 1'b0;
      write_collision_flag_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      if (rd & a_stat & (done_ff | write_collision_flag_ff))
        armed_ff <= 1'b1;
      else if (data_acc)
        armed_ff <= 1'b0;
      if (done_set)
        done_ff <= 1'b1;
      else if (IRQ_ACK_IN | (data_acc & armed_ff))
        done_ff <= 1'b0;
      if (write_collision_flag_set)
        write_collision_flag_ff <= 1'b1;
      else if (data_acc & armed_ff)
        write_collision_flag_ff <= 1'b0;
    end
  end
  assign IRQ_OUT = done_ff & ctrl_ff[`SPIMSP_CTRL_IE] & GLOBAL_IRQ_EN_IN;
  // ----------------------------------------
  // shift engine and clock generator
  // ----------------------------------------
  wire start = data_wr & ~busy_ff & en;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN) begin
      shift_ff <= 8'h00;
      rxbuf_ff <= 8'h00;
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      sck_ff <= 1'b0;
      div_ff <= 7'h00;
      half_ff <= 1'b0;
      mosi_ff <= 1'b0;
      msamp_d_ff <= 2'h0;
      mlast_d_ff <= 2'h0;
      mrx_ff <= 8'h00;
    end else if (!en || demote || ss_rise) begin
      msamp_d_ff <= 2'h0;
      mlast_d_ff <= 2'h0;
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      half_ff <= 1'b0;
      div_ff <= 7'h00;
      sck_ff <= cpol;
      if (ss_rise)
        shift_ff <= 8'h00;
      if (!en && data_wr)
        shift_ff <= PWDATA_IN[7:0];
    end else begin
      // delayed master sample strobes
      msamp_d_ff <= {msamp_d_ff[0], samp & master_role_select};
      mlast_d_ff <= {mlast_d_ff[0], last & master_role_select};
      if (msamp_d_ff[1])
        mrx_ff <= nxt_mrx;
      if (mlast_d_ff[1])
        rxbuf_ff <= nxt_mrx;
      // idle level follows polarity between bytes
      if (!busy_ff)
        sck_ff <= cpol;
      if (start) begin
        shift_ff <= PWDATA_IN[7:0];
        busy_ff <= master_role_select;
        div_ff <= 7'h00;
        half_ff <= 1'b0;
        if (!cpha)
          mosi_ff <= lsb ? PWDATA_IN[0] : PWDATA_IN[7];
      end else begin
        if (busy_ff & master_role_select)
          div_ff <= tick ? 7'h00 : div_ff + 7'h01;
        if (tick) begin
          sck_ff <= ~sck_ff;
          half_ff <= ~half_ff;
        end
        if (setup)
          mosi_ff <= out_bit;
        if (samp) begin
          shift_ff <= lsb ? {din, shift_ff[7:1]} : {shift_ff[6:0], din};
          cnt_ff <= cnt_ff + 3'h1;
        end
        if (last && !master_role_select) begin
          rxbuf_ff <= lsb ? {din, shift_ff[7:1]} : {shift_ff[6:0], din};
          busy_ff <= 1'b0;
        end
        if (m_end)
          busy_ff <= 1'b0;
        // slave is busy while bits are mid-byte
        if (!master_role_select && samp && !last)
          busy_ff <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge CLK_SYS_IN) begin
    if (!RST_N_IN)
      rdata_ff <= 32'h00000000;
    else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
      if (a_ctrl)
        rdata_ff <= {24'h000000, ctrl_ff};
      else if (a_stat)
        rdata_ff <= {24'h000000, done_ff, write_collision_flag_ff, 5'h00, dbl_ff};
      else if (a_data)
        rdata_ff <= {24'h000000, rxbuf_ff};
      else if (a_pin)
        rdata_ff <= {27'h0000000, pin_ff};
      else
        rdata_ff <= 32'h00000000;
    end
  end
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  wire m_role = en & master_role_select;
  assign SCK_OUT = sck_ff;
  assign SCK_OE_OUT = m_role & pin_ff[`SPIMSP_PIN_SCK_OE];
  assign MOSI_OUT = mosi_ff;
  assign MOSI_OE_OUT = m_role & pin_ff[`SPIMSP_PIN_MOSI_OE];
  // slave miso: with phase zero the first bit shows straight from the shift register
  assign MISO_OUT = (cnt_ff == 3'h0 && !cpha) ? out_bit : mosi_ff;
  assign MISO_OE_OUT = s_active & pin_ff[`SPIMSP_PIN_MISO_OE];
  assign SS_N_OUT = pin_ff[`SPIMSP_PIN_SS_LVL];
  assign SS_N_OE_OUT = master_role_select & pin_ff[`SPIMSP_PIN_SS_OUT];
endmodule
`default_nettype wire

// File: spimsp_port_properties.sv
// Purpose: port-level checks of the serial port
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the port from the bench top
`timescale 1ns/1ps
`default_nettype none
module spimsp_port_properties (
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic GLOBAL_IRQ_EN_IN,
  input wire logic IRQ_ACK_IN,
  input wire logic IRQ_OUT,
  input wire logic MOSI_OE_OUT,
  input wire logic SCK_OE_OUT,
  input wire logic MISO_OE_OUT,
  input wire logic SS_N_IN,
  input wire logic SS_N_OE_OUT
);
  // single clock domain
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  // bus answers
  chk_ready_high: assert property (PREADY_OUT) else $error("pready low");
  chk_err_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("pslverr outside access");
  chk_upper_zero: assert property (PRDATA_OUT[31:8] == 24'h000000) else $error("upper bits");
  // interrupt gating and clearing
  chk_irq_gate: assert property (IRQ_OUT |-> GLOBAL_IRQ_EN_IN) else $error("irq ungated");
  chk_irq_clear: assert property (IRQ_OUT && IRQ_ACK_IN |=> !IRQ_OUT)
    else $error("irq kept after ack");
  // pin directions
  chk_miso_quiet: assert property (SS_N_IN [*4] |-> !MISO_OE_OUT)
    else $error("miso driven while deselected");
  chk_demote_pins: assert property ((!SS_N_IN && !SS_N_OE_OUT) [*5] |->
    !MOSI_OE_OUT && !SCK_OE_OUT) else $error("mosi or sck driven while selected");
  chk_mosi_drop: assert property ($fell(MOSI_OE_OUT) |->
    $past(PSEL_IN && PENABLE_IN && PWRITE_IN) || !$past(SS_N_OE_OUT))
    else $error("mosi released without cause");
endmodule
`default_nettype wire

// File: spimsp_slave_model.sv
// Purpose: far-side serial slave for master transfers
// Assumes: mode is {lsb first, polarity, phase}
// Notes: released miso shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module spimsp_slave_model (
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic ss_n_in,
  input wire logic [2:0] mode_in,
  input wire logic [7:0] tx_in,
  output logic miso_out,
  output logic [7:0] rx_out
);
  logic [7:0] sh;
  int n;
  // rises on the sample edge in every mode
  wire s = sck_in ^ mode_in[1] ^ mode_in[0];
  initial miso_out = 1'b0;
  // select loads the byte and shows its first bit
  always @(negedge ss_n_in) begin
    n = 0;
    sh = tx_in;
    miso_out = mode_in[2] ? sh[0] : sh[7];
  end
  always @(posedge ss_n_in) miso_out = ~miso_out;
  // sample edge shifts one bit in
  always @(posedge s) if (!ss_n_in && n < 8) begin
    sh = mode_in[2] ? {mosi_in, sh[7:1]} : {sh[6:0], mosi_in};
    n++;
    if (n == 8) rx_out = sh;
  end
  // setup edge shows the next bit
  always @(negedge s) if (!ss_n_in && n > 0 && n < 8) miso_out = mode_in[2] ? sh[0] : sh[7];
endmodule
`default_nettype wire

// File: spimsp_port_tb.sv
// Purpose: self-checking bench of the serial port
// Assumes: 250 MHz clock, APB master tasks, fixed seed
// Notes: bench acts as far master in slave role
`include "spimsp_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module spimsp_port_tb;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, gie = 0, ack = 0;
  logic bsck = 0, bmosi = 0, bss = 1, sq = 0;
  logic [11:0] pa = 0;
  logic [31:0] pwd = 0, q;
  logic [2:0] md = 0;
  logic [7:0] tx = 0, d, r;
  int mismatches = 0, checks = 0, cyc = 0, ne, t0, t1, dv;
  wire [31:0] prd;
  wire [7:0] rx;
  wire prdy, perr, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, mmiso;
  // pin levels from every driver
  wire sck = sck_oe ? sck_o : bsck;
  wire mosi = mosi_oe ? mosi_o : bmosi;
  wire miso = miso_oe ? miso_o : mmiso;
  wire ss = ss_oe ? ss_o : bss;
  spimsp_port u_dut (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .GLOBAL_IRQ_EN_IN(gie), .IRQ_ACK_IN(ack),
    .IRQ_OUT(irq), .SCK_IN(sck), .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe), .MOSI_IN(mosi),
    .MOSI_OUT(mosi_o), .MOSI_OE_OUT(mosi_oe), .MISO_IN(miso), .MISO_OUT(miso_o),
    .MISO_OE_OUT(miso_oe), .SS_N_IN(ss), .SS_N_OUT(ss_o), .SS_N_OE_OUT(ss_oe));
  spimsp_slave_model u_sl (.sck_in(sck), .mosi_in(mosi), .ss_n_in(ss), .mode_in(md),
    .tx_in(tx), .miso_out(mmiso), .rx_out(rx));
  initial forever #2 clk = ~clk;
  // sck edge counter and timeout
  always @(posedge clk) begin
    cyc++;
    if (sck_o !== sq) begin
      ne++;
      if (ne == 1) t0 = cyc;
      t1 = cyc;
    end
    sq = sck_o;
    if (cyc == 40000) begin
      mismatches++;
      conclude;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1;
    pwr <= w;
    pa <= a;
    pwd <= wd;
    @(posedge clk) pen <= 1;
    @(posedge clk);
    while (prdy !== 1'b1) @(posedge clk);
    q = prd;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask
  task waitdone;
    q = 0;
    while (q[7] !== 1'b1) apb(0, `SPIMSP_STAT_OFF, 0);
  endtask
  // far master byte, half period of 8 clocks
  task sbyte(input logic [7:0] v, input int nb, output logic [7:0] o);
    int b;
    for (int k = 0; k < nb; k++) begin
      b = md[2] ? k : 7 - k;
      if (!md[0]) bmosi <= v[b];
      repeat (8) @(posedge clk);
      bsck <= ~md[1];
      if (md[0]) bmosi <= v[b];
      else o[b] = miso;
      repeat (8) @(posedge clk);
      bsck <= md[1];
      if (md[0]) o[b] = miso;
    end
    repeat (8) @(posedge clk);
  endtask
  function int divr(input logic x, input logic [1:0] s);
    divr = (x ? 2 : 4) << (2 * s);
    if (s == 2'h3) divr = divr / 2;
  endfunction
  task conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    d = $urandom(65643);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    // reset values, last address unmapped
    for (int j = 0; j < 5; j++) begin
      apb(0, 12'(j * 4), 0);
      chk("reset", q, j == 3 ? 32'h02 : 32'h00);
    end
    // master bytes over all rates and modes
    for (int i = 0; i < 8; i++) begin
      md = $urandom;
      md[1:0] = 2'(i + (i >> 2));
      tx = $urandom;
      d = $urandom;
      gie <= $urandom;
      dv = divr(i[2], i[1:0]);
      apb(1, `SPIMSP_PIN_OFF, 32'h17);
      apb(1, `SPIMSP_CTRL_OFF, {24'h0, d[0], 1'b1, md[2], 1'b1, md[1:0], i[1:0]});
      apb(1, `SPIMSP_STAT_OFF, {31'h0, i[2]});
      apb(1, `SPIMSP_PIN_OFF, 32'h15);
      ne = 0;
      apb(1, `SPIMSP_DATA_OFF, {24'h0, d});
      if (i == 0) apb(1, `SPIMSP_DATA_OFF, 32'hFF);
      waitdone;
      chk("stat", q[7:0], {1'b1, i == 0, 5'h0, i[2]});
      chk("irq", irq, d[0] & gie);
      ack <= 1;
      @(posedge clk) ack <= 0;
      @(posedge clk);
      chk("irq ack", irq, 0);
      repeat (dv) @(posedge clk);
      apb(0, `SPIMSP_DATA_OFF, 0);
      chk("rx", q, {24'h0, tx});
      chk("model rx", rx, d);
      chk("edges", ne, 16);
      chk("span", t1 - t0, 15 * dv / 2);
      chk("idle", sck_o, md[1]);
    end
    // select pulled low with select as input
    apb(1, `SPIMSP_PIN_OFF, 32'h14);
    gie <= 1;
    apb(1, `SPIMSP_CTRL_OFF, 32'hD0);
    bss <= 0;
    repeat (8) @(posedge clk);
    apb(0, `SPIMSP_CTRL_OFF, 0);
    chk("demote", q, 32'hC0);
    chk("demote irq", irq, 1);
    apb(0, `SPIMSP_STAT_OFF, 0);
    chk("demote done", q[7], 1);
    apb(0, `SPIMSP_DATA_OFF, 0);
    bss <= 1;
    apb(1, `SPIMSP_CTRL_OFF, 32'hD0);
    apb(0, `SPIMSP_CTRL_OFF, 0);
    chk("remaster", q, 32'hD0);
    // port disabled
    apb(1, `SPIMSP_CTRL_OFF, 32'h10);
    apb(1, `SPIMSP_PIN_OFF, 32'h15);
    ne = 0;
    apb(1, `SPIMSP_DATA_OFF, 32'h5A);
    repeat (300) @(posedge clk);
    chk("off edges", ne, 0);
    // slave role, rate bits set
    md = $urandom;
    tx = $urandom;
    d = $urandom;
    bsck <= md[1];
    apb(1, `SPIMSP_PIN_OFF, 32'h08);
    apb(1, `SPIMSP_CTRL_OFF, {24'h0, 2'h1, md[2], 1'b0, md[1:0], 2'h3});
    apb(1, `SPIMSP_DATA_OFF, {24'h0, tx});
    sbyte(8'hA5, 8, r);
    apb(0, `SPIMSP_STAT_OFF, 0);
    chk("ss high", q[7], 0);
    bss <= 0;
    sbyte(d, 8, r);
    bss <= 1;
    chk("miso", r, tx);
    waitdone;
    apb(0, `SPIMSP_DATA_OFF, 0);
    chk("slave rx", q, {24'h0, d});
    bss <= 0;
    sbyte(8'hFF, 3, r);
    bss <= 1;
    repeat (8) @(posedge clk);
    bss <= 0;
    sbyte(~d, 8, r);
    bss <= 1;
    waitdone;
    apb(0, `SPIMSP_DATA_OFF, 0);
    chk("resync", q, {24'h0, ~d});
    conclude;
  end
endmodule
bind spimsp_port spimsp_port_properties u_chk (.*);
`default_nettype wire
